// file: hdl/ouvg_over_under_voltage_guard.sv
// Control logic of two over/under voltage protection channels behind an APB slave.
// Assumes raw comparator results arrive asynchronously from the analog front end and
// that the PWM generator supplies the normal output levels on the same clock.
`timescale 1ns/1ps
module ouvg_over_under_voltage_guard
	import ouvg_pkg::*;
#(
	parameter int NUM_CH = `OUVG_NUM_CH
) (
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire logic [NUM_CH-1:0]   overVoltRawResult,
	input  wire logic [NUM_CH-1:0]   underVoltRawResult,
	output ouvg_cmp_ctrl_s [NUM_CH-1:0] overVoltCtrl,
	output ouvg_cmp_ctrl_s [NUM_CH-1:0] underVoltCtrl,
	output logic [NUM_CH-1:0]        overVoltIrqTrigger,
	output logic [NUM_CH-1:0]        underVoltIrqTrigger,
	input  wire logic [3:0]          pwmNormalOut,
	output logic [3:0]               pwmOut
);
	// pwm order: 0 pair0 high, 1 pair0 low, 2 pair1 high, 3 pair1 low

	initial begin
		if (NUM_CH != 2)
			$error("ouvg: two channels are mapped");
	end

	typedef struct packed {
		ouvg_chan_s [1:0] ch;
		logic [3:0]       faultState;
		logic             ready;
		logic [31:0]      rdata;
		logic             slvErr;
		logic [3:0]       pwm;
	} ouvg_state_s;

	ouvg_state_s stReg;
	ouvg_state_s stNext;

	function automatic logic [5:0] filtLen(input logic [1:0] sel);
		case (ouvg_filt_e'(sel))
			OUVG_FILT_8:  filtLen = `OUVG_FILT_SHORT;
			OUVG_FILT_16: filtLen = `OUVG_FILT_MID;
			OUVG_FILT_32: filtLen = `OUVG_FILT_LONG;
			default:      filtLen = 6'd0;
		endcase
	endfunction : filtLen

	// Counts cycles the synchronised raw value differs from the stable one
	function automatic ouvg_filt_s filtStep(input ouvg_filt_s f, input logic raw, input logic [1:0] sel,
		input logic en);
		ouvg_filt_s r;
		r = f;
		if (!en) begin
			r = '0;
		end else if (filtLen(sel) == 6'd0) begin
			r.stable = raw;
			r.count  = 6'd0;
		end else if (raw == f.stable) begin
			r.count = 6'd0;
		end else if (f.count + 6'd1 >= filtLen(sel)) begin
			r.stable = raw;
			r.count  = 6'd0;
		end else begin
			r.count = f.count + 6'd1;
		end
		return r;
	endfunction : filtStep

	function automatic logic [7:0] laneWrite(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] msk);
		return (old & ~msk) | (wd & msk);
	endfunction : laneWrite

	logic        access;
	logic [11:0] chOfs;
	logic        chSel;
	logic        chHit;
	logic [3:0]  ovActive;
	logic [3:0]  uvActive;

	assign access = psel && penable;
	assign chSel  = paddr[5];
	assign chOfs  = {7'h00, paddr[4:0]};
	assign chHit  = (paddr[11:6] == 6'h00);

	always_comb begin
		stNext = stReg;
		stNext.ready  = 1'b0;
		stNext.slvErr = 1'b0;
		for (int c = 0; c < 2; c++) begin
			stNext.ch[c].rawSync1 = {underVoltRawResult[c], overVoltRawResult[c]};
			stNext.ch[c].rawSync2 = stReg.ch[c].rawSync1;
			stNext.ch[c].ovFilt = filtStep(stReg.ch[c].ovFilt, stReg.ch[c].rawSync2[0],
				stReg.ch[c].ovCtrl[1:0], stReg.ch[c].ovCtrl[`OUVG_CTRL_EN_BIT]);
			stNext.ch[c].uvFilt = filtStep(stReg.ch[c].uvFilt, stReg.ch[c].rawSync2[1],
				stReg.ch[c].uvCtrl[1:0], stReg.ch[c].uvCtrl[`OUVG_CTRL_EN_BIT]);
		end
		if (psel && penable && !stReg.ready) begin
			stNext.ready = 1'b1;
			stNext.rdata = 32'h0000_0000;
			if (chHit && pwrite && pstrb[0]) begin
				if (chOfs == `OUVG_OFS_OV_CODE) begin
					stNext.ch[chSel].ovCode = pwdata[7:0];
				end else if (chOfs == `OUVG_OFS_UV_CODE) begin
					stNext.ch[chSel].uvCode = pwdata[7:0];
				end else if (chOfs == `OUVG_OFS_OV_CTRL) begin
					stNext.ch[chSel].ovCtrl = pwdata[7:0] & `OUVG_CTRL_MASK;
				end else if (chOfs == `OUVG_OFS_UV_CTRL) begin
					stNext.ch[chSel].uvCtrl = pwdata[7:0] & `OUVG_CTRL_MASK;
				end else if (chOfs == `OUVG_OFS_OV_TRIM) begin
					stNext.ch[chSel].ovTrim = laneWrite(stReg.ch[chSel].ovTrim, pwdata[7:0], `OUVG_TRIM_MASK);
				end else if (chOfs == `OUVG_OFS_UV_TRIM) begin
					stNext.ch[chSel].uvTrim = laneWrite(stReg.ch[chSel].uvTrim, pwdata[7:0], `OUVG_TRIM_MASK);
				end else if (chOfs == `OUVG_OFS_PROT_EN) begin
					stNext.ch[chSel].protEn = pwdata[7:0];
				end else begin
					stNext.slvErr = 1'b1;
				end
			end else if (chHit && !pwrite) begin
				if (chOfs == `OUVG_OFS_OV_CODE) begin
					stNext.rdata = {24'h000000, stReg.ch[chSel].ovCode};
				end else if (chOfs == `OUVG_OFS_UV_CODE) begin
					stNext.rdata = {24'h000000, stReg.ch[chSel].uvCode};
				end else if (chOfs == `OUVG_OFS_OV_CTRL) begin
					stNext.rdata = {24'h000000, stReg.ch[chSel].ovCtrl};
				end else if (chOfs == `OUVG_OFS_UV_CTRL) begin
					stNext.rdata = {24'h000000, stReg.ch[chSel].uvCtrl};
				end else if (chOfs == `OUVG_OFS_OV_TRIM) begin
					stNext.rdata = {24'h000000, stReg.ch[chSel].rawSync2[0], stReg.ch[chSel].ovTrim[6:0]};
				end else if (chOfs == `OUVG_OFS_UV_TRIM) begin
					stNext.rdata = {24'h000000, stReg.ch[chSel].rawSync2[1], stReg.ch[chSel].uvTrim[6:0]};
				end else if (chOfs == `OUVG_OFS_PROT_EN) begin
					stNext.rdata = {24'h000000, stReg.ch[chSel].protEn};
				end else begin
					stNext.slvErr = 1'b1;
				end
			end else if (chHit) begin
				stNext.slvErr = 1'b0;
			end else if (paddr == `OUVG_OFS_FAULT_ST) begin
				if (pwrite && pstrb[0])
					stNext.faultState = pwdata[3:0];
				else if (!pwrite)
					stNext.rdata = {28'h0000000, stReg.faultState};
			end else if (paddr == `OUVG_OFS_STATUS) begin
				if (pwrite)
					stNext.slvErr = 1'b1;
				else
					stNext.rdata = {24'h000000,
						stReg.ch[1].uvFilt.stable, stReg.ch[1].ovFilt.stable,
						stReg.ch[0].uvFilt.stable, stReg.ch[0].ovFilt.stable,
						stReg.ch[1].rawSync2, stReg.ch[0].rawSync2};
			end else begin
				stNext.slvErr = 1'b1;
			end
		end
		// Fault override per output; low nibble of protect enables is over, high nibble under
		ovActive = 4'h0;
		uvActive = 4'h0;
		for (int c = 0; c < 2; c++) begin
			ovActive = ovActive | (stReg.ch[c].protEn[3:0] & {4{stReg.ch[c].ovFilt.stable}});
			uvActive = uvActive | (stReg.ch[c].protEn[7:4] & {4{stReg.ch[c].uvFilt.stable}});
		end
		for (int k = 0; k < 4; k++) begin
			stNext.pwm[k] = (ovActive[k] || uvActive[k]) ? stReg.faultState[k] : pwmNormalOut[k];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int c = 0; c < 2; c++) begin
				stReg.ch[c].ovCode   <= `OUVG_CODE_RESET;
				stReg.ch[c].uvCode   <= `OUVG_CODE_RESET;
				stReg.ch[c].ovCtrl   <= `OUVG_CTRL_RESET;
				stReg.ch[c].uvCtrl   <= `OUVG_CTRL_RESET;
				stReg.ch[c].ovTrim   <= `OUVG_TRIM_RESET;
				stReg.ch[c].uvTrim   <= `OUVG_TRIM_RESET;
				stReg.ch[c].protEn   <= `OUVG_PROT_RESET;
				stReg.ch[c].rawSync1 <= 2'b00;
				stReg.ch[c].rawSync2 <= 2'b00;
				stReg.ch[c].ovFilt   <= '0;
				stReg.ch[c].uvFilt   <= '0;
			end
			stReg.faultState <= `OUVG_FAULT_RESET;
			stReg.ready      <= 1'b0;
			stReg.rdata      <= 32'h0000_0000;
			stReg.slvErr     <= 1'b0;
			stReg.pwm        <= 4'h0;
		end else begin
			stReg <= stNext;
		end
	end

	// Analog controls; a cleared enable powers the comparator and DAC down
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			overVoltCtrl[c].enable        = stReg.ch[c].ovCtrl[`OUVG_CTRL_EN_BIT];
			overVoltCtrl[c].hysteresisOn  = stReg.ch[c].ovCtrl[`OUVG_CTRL_HY_BIT];
			overVoltCtrl[c].refSelect     = ouvg_ref_e'(stReg.ch[c].ovCtrl[3:2]);
			overVoltCtrl[c].thresholdCode = stReg.ch[c].ovCode;
			overVoltCtrl[c].trimMode      = stReg.ch[c].ovTrim[6];
			overVoltCtrl[c].trimRefSide   = stReg.ch[c].ovTrim[5];
			overVoltCtrl[c].trimCode      = stReg.ch[c].ovTrim[4:0];
			underVoltCtrl[c].enable        = stReg.ch[c].uvCtrl[`OUVG_CTRL_EN_BIT];
			underVoltCtrl[c].hysteresisOn  = stReg.ch[c].uvCtrl[`OUVG_CTRL_HY_BIT];
			underVoltCtrl[c].refSelect     = ouvg_ref_e'(stReg.ch[c].uvCtrl[3:2]);
			underVoltCtrl[c].thresholdCode = stReg.ch[c].uvCode;
			underVoltCtrl[c].trimMode      = stReg.ch[c].uvTrim[6];
			underVoltCtrl[c].trimRefSide   = stReg.ch[c].uvTrim[5];
			underVoltCtrl[c].trimCode      = stReg.ch[c].uvTrim[4:0];
			overVoltIrqTrigger[c]  = stReg.ch[c].ovFilt.stable;
			underVoltIrqTrigger[c] = stReg.ch[c].uvFilt.stable;
		end
	end

	assign pready  = stReg.ready;
	assign prdata  = stReg.rdata;
	assign pslverr = stReg.slvErr;
	assign pwmOut  = stReg.pwm;

	// Assertions
	sequence s_ovHeld8(int c);
		(stReg.ch[0].rawSync2[0] == 1'b1) [*8];
	endsequence

	AST_CTRL_HIGH_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stReg.ch[0].ovCtrl[7:6] == 2'b00 && stReg.ch[1].uvCtrl[7:6] == 2'b00)
		else $error("control bits 7:6 not zero");

	AST_NOFILT_FOLLOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(stReg.ch[0].ovCtrl[5:0] ==? 6'b1?_??00 && $stable(stReg.ch[0].ovCtrl)) |=>
		overVoltIrqTrigger[0] == $past(stReg.ch[0].rawSync2[0]))
		else $error("unfiltered trigger does not follow raw");

	AST_FILT8_RISE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(stReg.ch[0].ovCtrl[5:0] ==? 6'b1?_??01 && !overVoltIrqTrigger[0] && stReg.ch[0].ovFilt.count == 6'd0)
		##0 s_ovHeld8(0) |=> overVoltIrqTrigger[0])
		else $error("8-cycle filter did not settle");

	AST_FILT_NO_EARLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(underVoltIrqTrigger[0]) && stReg.ch[0].uvCtrl[1:0] == 2'b10 |->
		$past(stReg.ch[0].rawSync2[1], 15))
		else $error("16-cycle trigger rose early");

	AST_DISABLED_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!stReg.ch[1].ovCtrl[`OUVG_CTRL_EN_BIT] |=> !overVoltIrqTrigger[1])
		else $error("disabled comparator raised trigger");

	AST_UV_DISABLED_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!underVoltCtrl[0].enable |=> !underVoltIrqTrigger[0])
		else $error("disabled under comparator raised trigger");

	AST_FORCE_FAULT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stReg.ch[0].protEn[0] && overVoltIrqTrigger[0] |=> pwmOut[0] == $past(stReg.faultState[0]))
		else $error("protected output not forced");

	AST_RELEASE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ovActive == 4'h0 && uvActive == 4'h0) |=> pwmOut == $past(pwmNormalOut))
		else $error("output not released");

	AST_UV_UNPROTECTED: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!stReg.ch[1].protEn[7] && !stReg.ch[0].protEn[7] && !ovActive[3] |=> pwmOut[3] == $past(pwmNormalOut[3]))
		else $error("unprotected output affected");

	AST_PREADY_ONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pready |=> !pready)
		else $error("pready held two cycles");
endmodule : ouvg_over_under_voltage_guard

// file: pkg/ouvg_defines.svh
// Register offsets, field positions, reset values and filter lengths of the voltage guard.
// Assumes inclusion by bare name from the package only; the design module uses its macros without including it.
`ifndef OUVG_DEFINES_SVH
`define OUVG_DEFINES_SVH

`define OUVG_NUM_CH        2
`define OUVG_CH_STRIDE     12'h020
`define OUVG_OFS_OV_CODE   12'h000
`define OUVG_OFS_UV_CODE   12'h004
`define OUVG_OFS_OV_CTRL   12'h008
`define OUVG_OFS_UV_CTRL   12'h00c
`define OUVG_OFS_OV_TRIM   12'h010
`define OUVG_OFS_UV_TRIM   12'h014
`define OUVG_OFS_PROT_EN   12'h018
`define OUVG_OFS_FAULT_ST  12'h040
`define OUVG_OFS_STATUS    12'h044

`define OUVG_CTRL_MASK     8'h3f
`define OUVG_CTRL_EN_BIT   5
`define OUVG_CTRL_HY_BIT   4
`define OUVG_TRIM_MASK     8'h7f
`define OUVG_TRIM_RESET    8'h10
`define OUVG_CODE_RESET    8'h00
`define OUVG_CTRL_RESET    8'h00
`define OUVG_PROT_RESET    8'h00
`define OUVG_FAULT_RESET   4'h0

`define OUVG_FILT_SHORT    6'd8
`define OUVG_FILT_MID      6'd16
`define OUVG_FILT_LONG     6'd32

`endif

// file: pkg/ouvg_pkg.sv
// Types shared by the voltage guard design.
// Assumes the defines header sits on the include path.
package ouvg_pkg;
	`include "ouvg_defines.svh"

	typedef enum logic [1:0] {
		OUVG_FILT_NONE,
		OUVG_FILT_8,
		OUVG_FILT_16,
		OUVG_FILT_32
	} ouvg_filt_e;

	typedef enum logic [1:0] {
		OUVG_REF_SUPPLY,
		OUVG_REF_EXT_PIN,
		OUVG_REF_INT_BUF,
		OUVG_REF_SUPPLY_ALT
	} ouvg_ref_e;

	// One comparator's analog controls toward the front end
	typedef struct packed {
		logic      enable;
		logic      hysteresisOn;
		ouvg_ref_e refSelect;
		logic [7:0] thresholdCode;
		logic      trimMode;
		logic      trimRefSide;
		logic [4:0] trimCode;
	} ouvg_cmp_ctrl_s;

	// One comparator's filter state
	typedef struct packed {
		logic       stable;
		logic [5:0] count;
	} ouvg_filt_s;

	typedef struct packed {
		logic [7:0] ovCode;
		logic [7:0] uvCode;
		logic [7:0] ovCtrl;
		logic [7:0] uvCtrl;
		logic [7:0] ovTrim;
		logic [7:0] uvTrim;
		logic [7:0] protEn;
		logic [1:0] rawSync1;
		logic [1:0] rawSync2;
		ouvg_filt_s ovFilt;
		ouvg_filt_s uvFilt;
	} ouvg_chan_s;
endpackage : ouvg_pkg

// file: dv/ouvg_front_end_model.sv
// Behavioural model of the comparators and threshold DACs seen by the voltage guard.
// Assumes the bench drives each monitored input as an 8-bit level on the DAC scale.
`timescale 1ns/1ps
module ouvg_front_end_model
	import ouvg_pkg::*;
#(
	parameter int NUM_CH = 2
) (
	input  wire ouvg_cmp_ctrl_s [NUM_CH-1:0] ovCtrl,
	input  wire ouvg_cmp_ctrl_s [NUM_CH-1:0] uvCtrl,
	input  wire logic [NUM_CH-1:0][7:0]      level,
	output logic [NUM_CH-1:0]                ovRaw,
	output logic [NUM_CH-1:0]                uvRaw
);
	// Every reference choice is taken as full scale, so the level compares straight to the code
	// Buffered internal reference is taken as live: software turns the converter buffer on first
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			ovRaw[i] = ovCtrl[i].enable && (level[i] > ovCtrl[i].thresholdCode);
			uvRaw[i] = uvCtrl[i].enable && (level[i] < uvCtrl[i].thresholdCode);
		end
	end
endmodule : ouvg_front_end_model

// file: dv/over_under_voltage_guard_test.sv
// Self-checking bench of the voltage guard: APB tasks, front-end model, fixed PWM levels.
// Assumes the design answers each APB access within a bounded number of cycles.
`timescale 1ns/1ps
module over_under_voltage_guard_test;
	import ouvg_pkg::*;
	logic                  ref_clk = 1'b0;
	logic                  sys_rst = 1'b1;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [11:0]           paddr = 12'h000;
	logic [31:0]           pwdata = 32'h0;
	logic                  pready;
	logic [31:0]           prdata;
	logic                  pslverr;
	logic [1:0]            ovRaw;
	logic [1:0]            uvRaw;
	ouvg_cmp_ctrl_s [1:0]  ovCtrl;
	ouvg_cmp_ctrl_s [1:0]  uvCtrl;
	logic [1:0]            ovTrig;
	logic [1:0]            uvTrig;
	logic [3:0]            pwmNormal = 4'h9;
	logic [3:0]            pwmOut;
	logic [1:0][7:0]       level = '{8'h50, 8'h50};
	int                    errors = 0;
	int                    checks = 0;
	logic [31:0]           rdat;
	logic                  rerr;
	int                    n;

	always #20 ref_clk = ~ref_clk;

	ouvg_over_under_voltage_guard #(.NUM_CH(2)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .overVoltRawResult(ovRaw), .underVoltRawResult(uvRaw),
		.overVoltCtrl(ovCtrl), .underVoltCtrl(uvCtrl), .overVoltIrqTrigger(ovTrig),
		.underVoltIrqTrigger(uvTrig), .pwmNormalOut(pwmNormal), .pwmOut(pwmOut));
	ouvg_front_end_model #(.NUM_CH(2)) u_fe (.ovCtrl(ovCtrl), .uvCtrl(uvCtrl), .level(level),
		.ovRaw(ovRaw), .uvRaw(uvRaw));

	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
		apb(1'b0, a, 32'h0);
		chk({rerr, rdat}, {expErr, exp});
	endtask : rdc

	function automatic logic [11:0] adr(input int ch, input logic [11:0] ofs);
		return 12'(ch * 32) + ofs;
	endfunction : adr

	// Counts edges until the trigger takes the wanted level
	task automatic waitTrig(input logic want, input int lo, input int hi);
		n = 0;
		while (ovTrig[0] !== want && n < 60) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask : waitTrig

	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		for (int c = 0; c < 2; c++) begin
			rdc(adr(c, `OUVG_OFS_OV_CODE), 32'h00, 1'b0);
			rdc(adr(c, `OUVG_OFS_UV_CTRL), 32'h00, 1'b0);
			rdc(adr(c, `OUVG_OFS_OV_TRIM), 32'h10, 1'b0);
			rdc(adr(c, `OUVG_OFS_PROT_EN), 32'h00, 1'b0);
		end
		wr(adr(1, `OUVG_OFS_OV_CTRL), 32'hff);
		rdc(adr(1, `OUVG_OFS_OV_CTRL), 32'h3f, 1'b0);
		wr(adr(1, `OUVG_OFS_OV_CODE), 32'ha5);
		rdc(adr(1, `OUVG_OFS_OV_CODE), 32'ha5, 1'b0);
		chk({ovCtrl[1].enable, ovCtrl[1].hysteresisOn, ovCtrl[1].refSelect, ovCtrl[1].thresholdCode},
			{1'b1, 1'b1, OUVG_REF_SUPPLY_ALT, 8'ha5});
		wr(adr(1, `OUVG_OFS_OV_CTRL), 32'h06);
		chk({ovCtrl[1].enable, ovCtrl[1].hysteresisOn, ovCtrl[1].refSelect}, {2'b00, OUVG_REF_EXT_PIN});
		rdc(12'h080, 32'h0, 1'b1);
		wr(`OUVG_OFS_STATUS, 32'hff);
		chk({31'h0, rerr}, 32'h1);
		wr(adr(0, `OUVG_OFS_OV_CODE), 32'h80);
		wr(`OUVG_OFS_FAULT_ST, 32'h06);
		wr(adr(0, `OUVG_OFS_PROT_EN), 32'h03);
		for (int f = 0; f < 4; f++) begin
			wr(adr(0, `OUVG_OFS_OV_CTRL), {26'h0, 2'b10, 2'b00, 2'(f)});
			level[0] <= 8'h90;
			waitTrig(1'b1, (f == 0) ? 1 : (8 << (f - 1)) - 1, (f == 0) ? 4 : (8 << (f - 1)) + 4);
			repeat (2) @(posedge ref_clk);
			chk(pwmOut, 4'ha);
			level[0] <= 8'h10;
			waitTrig(1'b0, (f == 0) ? 1 : (8 << (f - 1)) - 1, (f == 0) ? 4 : (8 << (f - 1)) + 4);
			repeat (2) @(posedge ref_clk);
			chk(pwmOut, 4'h9);
		end
		level[0] <= 8'h90;
		repeat (3) @(posedge ref_clk);
		level[0] <= 8'h10;
		repeat (40) @(posedge ref_clk);
		chk({31'h0, ovTrig[0]}, 32'h0);
		level[0] <= 8'h90;
		repeat (40) @(posedge ref_clk);
		chk({31'h0, ovTrig[0]}, 32'h1);
		wr(adr(0, `OUVG_OFS_OV_CTRL), 32'h01);
		repeat (3) @(posedge ref_clk);
		chk({ovCtrl[0].enable, ovTrig[0], pwmOut}, {2'b00, 4'h9});
		wr(adr(1, `OUVG_OFS_UV_CODE), 32'h40);
		wr(adr(1, `OUVG_OFS_PROT_EN), 32'hc0);
		wr(adr(1, `OUVG_OFS_UV_CTRL), 32'h22);
		level[1] <= 8'h30;
		repeat (24) @(posedge ref_clk);
		chk({uvCtrl[1].enable, uvTrig, ovTrig, pwmOut}, {1'b1, 2'b10, 2'b00, 4'h5});
		rdc(`OUVG_OFS_STATUS, 32'h88, 1'b0);
		rdc(adr(1, `OUVG_OFS_UV_TRIM), 32'h90, 1'b0);
		wr(adr(1, `OUVG_OFS_UV_CTRL), 32'h00);
		repeat (4) @(posedge ref_clk);
		chk({uvCtrl[1].enable, uvTrig, pwmOut}, {3'b000, 4'h9});
		report_and_stop();
	end
endmodule : over_under_voltage_guard_test
